// [asr_shift16.sv]
// Summary of operation
// - The delay length is eight times select bit 3 plus four times bit 2 plus twice bit 1 plus bit 0 plus one.
// - Select 0000 gives a one-stage line and select 1111 gives a sixteen-stage line.
// - Sixteen stages are always stored and the select only chooses the stage that drives the output.
// - The preload is a 16-bit value whose leftmost hex digit holds the highest stages.
// - With no preload given every stage comes up cleared.
// - The preload sets both the stored stages and the visible output before any shift.
// - A rising edge with shift enable high and the output buffer not full loads the serial input into stage zero and moves every bit up one.
// - With shift enable low the edge is ignored and all stages keep their value.
// - The output shows an input bit once it has reached the stage chosen by the current select.
module asr_shift16
  import asr_pkg::*;
#(
  parameter int DEPTH_W = ASR_DEPTH_W,
  parameter int STAGES = ASR_STAGES,
  parameter logic [ASR_STAGES-1:0] PRELOAD = ASR_PRELOAD_RST
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire asr_ctl_t ctl,
  output logic shift_rdy,
  output logic tap_q,
  output logic tail_q,
  output logic tap_fresh,
  output asr_word_t out_word,
  output logic out_valid,
  input wire logic out_ready
);

  // the select field of the carrier is fixed, so the geometry is too
  if (DEPTH_W != ASR_DEPTH_W || STAGES != (1 << DEPTH_W)) begin : g_bad_geometry
    $error("asr_shift16: STAGES must be 2**DEPTH_W and DEPTH_W must match the select field");
  end

  // delay length in stages for a select value
  function automatic logic [DEPTH_W:0] sel_length(input logic [DEPTH_W-1:0] sel);
    logic [DEPTH_W:0] len;
    len = (DEPTH_W+1)'(8) * (DEPTH_W+1)'(sel[3])
        + (DEPTH_W+1)'(4) * (DEPTH_W+1)'(sel[2])
        + (DEPTH_W+1)'(2) * (DEPTH_W+1)'(sel[1])
        + (DEPTH_W+1)'(sel[0])
        + (DEPTH_W+1)'(1);
    return len;
  endfunction : sel_length

  logic stages_reg [STAGES];
  logic fresh_reg [STAGES];
  logic [STAGES-1:0] stages_vec;
  logic [STAGES-1:0] fresh_vec;
  logic [DEPTH_W-1:0] depth_sel;
  logic [DEPTH_W:0] line_len;
  logic [DEPTH_W-1:0] tap_idx;
  logic shift_go;
  logic buf_in_ready;
  asr_word_t push_word;
  logic [$bits(asr_word_t)-1:0] buf_out_data;

  assign depth_sel = ctl.depth_sel;
  assign line_len = sel_length(depth_sel);
  assign tap_idx = DEPTH_W'(line_len - (DEPTH_W+1)'(1));

  // a full buffer holds the line still, so no delayed bit is lost
  assign shift_rdy = buf_in_ready;
  assign shift_go = ctl.shift_en && buf_in_ready;

  // storage: all stages shift together; the select never touches them
  for (genvar i = 0; i < STAGES; i++) begin : g_stage
    if (i == 0) begin : g_head
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          stages_reg[i] <= PRELOAD[i];
        end else if (shift_go) begin
          stages_reg[i] <= ctl.din;
        end
      end
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          fresh_reg[i] <= 1'b0;
        end else if (shift_go) begin
          fresh_reg[i] <= 1'b1;
        end
      end
    end else begin : g_body
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          stages_reg[i] <= PRELOAD[i];
        end else if (shift_go) begin
          stages_reg[i] <= stages_reg[i-1];
        end
      end
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          fresh_reg[i] <= 1'b0;
        end else if (shift_go) begin
          fresh_reg[i] <= fresh_reg[i-1];
        end
      end
    end
    assign stages_vec[i] = stages_reg[i];
    assign fresh_vec[i] = fresh_reg[i];
  end

  // tap is a plain mux, so a select change shows at once
  assign tap_q = stages_reg[tap_idx];
  assign tap_fresh = fresh_reg[tap_idx];
  assign tail_q = stages_reg[STAGES-1];

  // each shift hands the bit leaving the chosen stage downstream
  assign push_word.tap_bit = tap_q;
  assign push_word.fresh = tap_fresh;
  assign push_word.depth_sel = depth_sel;

  asr_word_buf #(
    .WIDTH($bits(asr_word_t)),
    .DEPTH(ASR_BUF_DEPTH)
  ) u_word_buf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(ctl.shift_en),
    .in_ready(buf_in_ready),
    .in_data(push_word),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(buf_out_data)
  );

  assign out_word = asr_word_t'(buf_out_data);

  // checks

  property p_len_formula;
    @(posedge core_clk) disable iff (!rst_n)
    tap_q == stages_vec[(8 * depth_sel[3]) + (4 * depth_sel[2]) + (2 * depth_sel[1]) + depth_sel[0]];
  endproperty
  a_len_formula: assert property (p_len_formula) else $error("tap not at weighted select position");

  property p_len_ends;
    @(posedge core_clk) disable iff (!rst_n)
    (depth_sel == ASR_SEL_SHORTEST |-> tap_q == stages_vec[0] && line_len == 5'h01)
    and (depth_sel == ASR_SEL_LONGEST |-> tap_q == stages_vec[STAGES-1] && line_len == 5'h10);
  endproperty
  a_len_ends: assert property (p_len_ends) else $error("select end values give wrong length");

  property p_sel_keeps_data;
    @(posedge core_clk) disable iff (!rst_n)
    $changed(depth_sel) && !$past(shift_go) |-> stages_vec == $past(stages_vec);
  endproperty
  a_sel_keeps_data: assert property (p_sel_keeps_data) else $error("select change moved stored data");

  property p_preload_order;
    @(posedge core_clk) disable iff (!rst_n)
    !$past(rst_n) |-> tap_q == PRELOAD[tap_idx] && tail_q == PRELOAD[STAGES-1];
  endproperty
  a_preload_order: assert property (p_preload_order) else $error("preload bit order wrong at tap");

  property p_default_clear;
    @(posedge core_clk) disable iff (!rst_n)
    !$past(rst_n) && (PRELOAD == ASR_PRELOAD_RST) |-> stages_vec == 16'h0000;
  endproperty
  a_default_clear: assert property (p_default_clear) else $error("default preload left stages set");

  property p_preload_visible;
    @(posedge core_clk) disable iff (!rst_n)
    !$past(rst_n) |-> stages_vec == PRELOAD && fresh_vec == 16'h0000 && !tap_fresh;
  endproperty
  a_preload_visible: assert property (p_preload_visible) else $error("stages not at preload after config");

  property p_shift_moves;
    @(posedge core_clk) disable iff (!rst_n)
    shift_go |=> stages_vec == {$past(stages_vec[STAGES-2:0]), $past(ctl.din)};
  endproperty
  a_shift_moves: assert property (p_shift_moves) else $error("shift did not move line by one");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_n)
    !ctl.shift_en |=> $stable(stages_vec) && $stable(fresh_vec);
  endproperty
  a_hold: assert property (p_hold) else $error("stages changed with shift enable low");

  sequence s_shift_at_two;
    shift_go && depth_sel == 4'h2;
  endsequence

  sequence s_three_shifts;
    s_shift_at_two ##1 s_shift_at_two ##1 s_shift_at_two;
  endsequence

  property p_arrival;
    @(posedge core_clk) disable iff (!rst_n)
    s_three_shifts ##1 (depth_sel == 4'h2) |-> tap_q == $past(ctl.din, 3) && tap_fresh;
  endproperty
  a_arrival: assert property (p_arrival) else $error("bit not at tap after three shifts");

  property p_tap_follows;
    @(posedge core_clk) disable iff (!rst_n)
    $changed(depth_sel) && $stable(stages_vec) |-> tap_q == stages_vec[depth_sel];
  endproperty
  a_tap_follows: assert property (p_tap_follows) else $error("tap lagged a select change");

  property p_stall_blocks;
    @(posedge core_clk) disable iff (!rst_n)
    ctl.shift_en && !shift_rdy |=> $stable(stages_vec);
  endproperty
  a_stall_blocks: assert property (p_stall_blocks) else $error("line shifted while buffer full");

  property p_word_carries_tap;
    @(posedge core_clk) disable iff (!rst_n)
    shift_go && !out_valid |=> out_valid && out_word.tap_bit == $past(tap_q)
      && out_word.depth_sel == $past(depth_sel);
  endproperty
  a_word_carries_tap: assert property (p_word_carries_tap) else $error("pushed word lost its tap bit");

  // fresh marks travel with the data, so a stage still at preload is told apart
  property p_fresh_moves;
    @(posedge core_clk) disable iff (!rst_n)
    shift_go |=> fresh_vec == {$past(fresh_vec[STAGES-2:0]), 1'b1};
  endproperty
  a_fresh_moves: assert property (p_fresh_moves) else $error("fresh marks did not move with the line");

  property p_reset_outputs;
    @(posedge core_clk) disable iff (!rst_n)
    !$past(rst_n) |-> !out_valid && shift_rdy && !tap_fresh;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not idle after config");

  // select decoding, checked against the weights rather than the mux
  property p_half_length;
    @(posedge core_clk) disable iff (!rst_n)
    depth_sel[2:0] == 3'h7 |-> tap_q == (depth_sel[3] ? stages_vec[STAGES-1] : stages_vec[STAGES/2-1]);
  endproperty
  a_half_length: assert property (p_half_length) else $error("top select bit did not halve the line");

  property p_len_value;
    @(posedge core_clk) disable iff (!rst_n)
    line_len == {1'b0, depth_sel} + 5'h01;
  endproperty
  a_len_value: assert property (p_len_value) else $error("line length not select plus one");

  property p_tail_still;
    @(posedge core_clk) disable iff (!rst_n)
    $changed(depth_sel) && !$past(shift_go) |-> $stable(tail_q);
  endproperty
  a_tail_still: assert property (p_tail_still) else $error("select change moved the last stage");

  sequence s_taken;
    shift_go;
  endsequence

  sequence s_idle;
    !ctl.shift_en;
  endsequence

  property p_single_stage;
    @(posedge core_clk) disable iff (!rst_n)
    s_taken ##1 (depth_sel == ASR_SEL_SHORTEST) |-> tap_q == $past(ctl.din) && tap_fresh;
  endproperty
  a_single_stage: assert property (p_single_stage) else $error("one-stage line did not show last bit");

  property p_sel_live;
    @(posedge core_clk) disable iff (!rst_n)
    s_idle ##1 $changed(depth_sel) |-> tap_q == stages_vec[depth_sel] && tap_fresh == fresh_vec[depth_sel];
  endproperty
  a_sel_live: assert property (p_sel_live) else $error("tap not at new select without a shift");

  property p_idle_tap_steady;
    @(posedge core_clk) disable iff (!rst_n)
    s_idle ##1 $stable(depth_sel) |-> $stable(tap_q) && $stable(tap_fresh);
  endproperty
  a_idle_tap_steady: assert property (p_idle_tap_steady) else $error("tap moved with shift enable low");

  // back-pressure: a full buffer must hold both the line and its marks
  property p_push_valid;
    @(posedge core_clk) disable iff (!rst_n)
    s_taken |=> out_valid;
  endproperty
  a_push_valid: assert property (p_push_valid) else $error("taken shift left no word");

  property p_word_fresh;
    @(posedge core_clk) disable iff (!rst_n)
    shift_go && !out_valid |=> out_word.fresh == $past(tap_fresh);
  endproperty
  a_word_fresh: assert property (p_word_fresh) else $error("pushed word lost its fresh mark");

  property p_full_stays;
    @(posedge core_clk) disable iff (!rst_n)
    ctl.shift_en && !shift_rdy && !out_ready |=> !shift_rdy;
  endproperty
  a_full_stays: assert property (p_full_stays) else $error("full buffer freed without a pop");

  property p_drain_frees;
    @(posedge core_clk) disable iff (!rst_n)
    !shift_go && out_valid && out_ready |=> shift_rdy;
  endproperty
  a_drain_frees: assert property (p_drain_frees) else $error("pop did not free a buffer entry");

  property p_refused_fresh;
    @(posedge core_clk) disable iff (!rst_n)
    ctl.shift_en && !shift_rdy |=> $stable(fresh_vec);
  endproperty
  a_refused_fresh: assert property (p_refused_fresh) else $error("fresh marks moved while buffer full");

endmodule : asr_shift16

// [asr_pkg.sv]
package asr_pkg;

  // geometry of the addressable delay line
  localparam int ASR_DEPTH_W = 4;
  localparam int ASR_STAGES = 16;

  // stage contents left behind by configuration when no pattern is given
  localparam logic [15:0] ASR_PRELOAD_RST = 16'h0000;

  // depth select ends: shortest and longest delay line
  localparam logic [3:0] ASR_SEL_SHORTEST = 4'h0;
  localparam logic [3:0] ASR_SEL_LONGEST = 4'hF;

  // entries of the output buffer
  localparam int ASR_BUF_DEPTH = 2;

  // request group from the driving logic
  typedef struct packed {
    logic shift_en;
    logic din;
    logic [3:0] depth_sel;
  } asr_ctl_t;

  // one delayed bit handed downstream, with the tap it came from
  typedef struct packed {
    logic tap_bit;
    logic fresh;
    logic [3:0] depth_sel;
  } asr_word_t;

endpackage : asr_pkg

// [asr_word_buf.sv]
module asr_word_buf
  import asr_pkg::*;
#(
  parameter int WIDTH = $bits(asr_word_t),
  parameter int DEPTH = ASR_BUF_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("asr_word_buf: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (PTR_W+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + (PTR_W+1)'(1);
    end else if (pop && !push) begin
      count_reg <= count_reg - (PTR_W+1)'(1);
    end
  end

  property p_buf_no_overrun;
    @(posedge core_clk) disable iff (!rst_n)
    !in_ready |-> count_reg == (PTR_W+1)'(DEPTH);
  endproperty
  a_buf_no_overrun: assert property (p_buf_no_overrun) else $error("buffer refused while not full");

  property p_buf_holds_word;
    @(posedge core_clk) disable iff (!rst_n)
    out_valid && !out_ready |=> out_valid && $stable(out_data);
  endproperty
  a_buf_holds_word: assert property (p_buf_holds_word) else $error("stalled word changed or dropped");

endmodule : asr_word_buf

// [asr_sink.sv]
module asr_sink
  import asr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic stall,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  // registered ready, so a stall bites one edge late like real fabric logic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= !stall;
    end
  end
endmodule : asr_sink

// [asr_shift16_tb.sv]
module asr_shift16_tb
  import asr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] PRE = 16'hA5C3;
  localparam logic [23:0] PAT = 24'hB4E29D;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic stall = 1'b0;
  asr_ctl_t ctl = '0;
  logic shift_rdy, tap_q, tail_q, tap_fresh, out_valid, out_ready, dflt_tap;
  asr_word_t out_word;
  int n_fail = 0;
  int checked = 0;
  logic [15:0] mdl = PRE;
  logic [15:0] fr = '0;
  asr_word_t expq[$];
  bit mon_on = 1'b0;

  asr_shift16 #(.PRELOAD(PRE)) DUT (.core_clk(core_clk), .rst_n(rst_n), .ctl(ctl), .shift_rdy(shift_rdy),
    .tap_q(tap_q), .tail_q(tail_q), .tap_fresh(tap_fresh), .out_word(out_word), .out_valid(out_valid),
    .out_ready(out_ready));
  // default preload instance, only its tap is judged
  asr_shift16 u_dflt (.core_clk(core_clk), .rst_n(rst_n), .ctl(ctl), .shift_rdy(), .tap_q(dflt_tap),
    .tail_q(), .tap_fresh(), .out_word(), .out_valid(), .out_ready(1'b1));
  asr_sink u_sink (.core_clk(core_clk), .rst_n(rst_n), .stall(stall), .out_ready(out_ready));

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic step(input logic en, input logic d, input logic [3:0] sel);
    @(posedge core_clk);
    ctl <= '{shift_en: en, din: d, depth_sel: sel};
  endtask : step

  // model advances at the negedge ahead of the edge that will take the shift
  always @(negedge core_clk) begin
    if (!rst_n) begin
      mdl = PRE;
      fr = '0;
      expq.delete();
    end else if (mon_on) begin
      chk(tap_q, mdl[ctl.depth_sel], "tap");
      chk(tail_q, mdl[15], "tail");
      chk(tap_fresh, fr[ctl.depth_sel], "fresh");
      chk(out_valid, expq.size() != 0, "valid");
      chk(shift_rdy, expq.size() < 2, "ready");
      if (out_valid === 1'b1 && out_ready === 1'b1 && expq.size() != 0) begin
        chk(out_word, expq.pop_front(), "word");
      end
      if (ctl.shift_en === 1'b1 && shift_rdy === 1'b1) begin
        expq.push_back('{tap_bit: mdl[ctl.depth_sel], fresh: fr[ctl.depth_sel], depth_sel: ctl.depth_sel});
        mdl = {mdl[14:0], ctl.din};
        fr = {fr[14:0], 1'b1};
      end
    end
  end

  task automatic t_preload;
    for (int i = 0; i < 16; i++) begin
      step(1'b0, i[0], i[3:0]);
      @(negedge core_clk);
      chk(dflt_tap, 1'b0, "default");
      chk(tap_q, PRE[i], "preload");
    end
    $display("t_preload done");
  endtask : t_preload

  task automatic t_hold;
    for (int i = 0; i < 6; i++) begin
      step(1'b0, i[0], 4'(i * 3));
    end
    @(negedge core_clk);
    chk(tail_q, PRE[15], "hold");
    $display("t_hold done");
  endtask : t_hold

  task automatic t_walk;
    for (int i = 0; i < 24; i++) begin
      step(1'b1, PAT[i], 4'(i * 7));
    end
    step(1'b0, 1'b0, ASR_SEL_LONGEST);
    @(negedge core_clk);
    chk(tap_q, PAT[8], "longest");
    step(1'b0, 1'b0, ASR_SEL_SHORTEST);
    @(negedge core_clk);
    chk(tap_q, PAT[23], "shortest");
    step(1'b0, 1'b0, 4'h9);
    @(negedge core_clk);
    chk(tap_q, PAT[14], "len ten");
    $display("t_walk done");
  endtask : t_walk

  task automatic t_stall;
    @(posedge core_clk);
    stall <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      step(1'b1, i[1], 4'h2);
    end
    @(negedge core_clk);
    chk(shift_rdy, 1'b0, "full");
    @(posedge core_clk);
    stall <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      step(1'b1, i[0], 4'h2);
    end
    repeat (4) step(1'b0, 1'b0, 4'h2);
    @(negedge core_clk);
    chk(out_valid, 1'b0, "drained");
    $display("t_stall done");
  endtask : t_stall

  task automatic t_reset;
    repeat (5) step(1'b1, 1'b1, ASR_SEL_LONGEST);
    @(posedge core_clk);
    rst_n <= 1'b0;
    ctl <= '0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    step(1'b0, 1'b0, ASR_SEL_LONGEST);
    @(negedge core_clk);
    chk(tail_q, PRE[15], "reinit");
    chk(tap_fresh, 1'b0, "reinit fresh");
    $display("t_reset done");
  endtask : t_reset

  task automatic close_out;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // the tests need about a hundred cycles; 4000 means a hang
  initial begin
    #200000;
    n_fail++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    mon_on <= 1'b1;
    t_preload();
    t_hold();
    t_walk();
    t_stall();
    t_reset();
    close_out();
  end
endmodule : asr_shift16_tb
